//--- logic/cnod_pkg.sv
// Shared constants, frame type and state codes for the CANopen node link.
package cnod_pkg;
	// System clock and bit timing.
	localparam int CLK_HZ = 200000000;
	localparam int TQ_PER_BIT = 16;
	localparam logic [3:0] SAMPLE_TQ = 4'hC;
	localparam logic [3:0] LAST_TQ = 4'hF;
	localparam logic [7:0] FRAME_BITS = 8'h80;
	// Rate codes; 3'h7 stands for no valid rate.
	localparam logic [2:0] RATE_500K = 3'h0;
	localparam logic [2:0] RATE_250K = 3'h1;
	localparam logic [2:0] RATE_125K = 3'h2;
	localparam logic [2:0] RATE_100K = 3'h3;
	localparam logic [2:0] RATE_50K = 3'h4;
	localparam logic [2:0] RATE_20K = 3'h5;
	localparam logic [2:0] RATE_10K = 3'h6;
	localparam logic [2:0] RATE_DEF = RATE_125K;
	// Clocks per time quantum for each rate.
	localparam logic [11:0] PRE_500K = 12'(CLK_HZ / (500000 * TQ_PER_BIT));
	localparam logic [11:0] PRE_250K = 12'(CLK_HZ / (250000 * TQ_PER_BIT));
	localparam logic [11:0] PRE_125K = 12'(CLK_HZ / (125000 * TQ_PER_BIT));
	localparam logic [11:0] PRE_100K = 12'(CLK_HZ / (100000 * TQ_PER_BIT));
	localparam logic [11:0] PRE_50K = 12'(CLK_HZ / (50000 * TQ_PER_BIT));
	localparam logic [11:0] PRE_20K = 12'(CLK_HZ / (20000 * TQ_PER_BIT));
	localparam logic [11:0] PRE_10K = 12'(CLK_HZ / (10000 * TQ_PER_BIT));
	// Times and the cycle counts derived from them.
	localparam int BOOT_MAX_S = 5;
	localparam int BOOT_DLY_US = 100;
	localparam int BOOT_CYC = BOOT_DLY_US * (CLK_HZ / 1000000);
	localparam int SDO_MAX_MS = 150;
	localparam int SDO_TYP_MS = 10;
	localparam int MS_CYC = CLK_HZ / 1000;
	localparam int SDO_MAX_CYC = SDO_MAX_MS * MS_CYC;
	// Frame on the link; byte 0 of the data field is data[7:0].
	typedef struct packed {
		logic [28:0] id;
		logic ide;
		logic [3:0] dlc;
		logic [63:0] data;
	} cnod_frame_s;
	// Function codes of the predefined connection set.
	localparam logic [10:0] COB_NMT = 11'h000;
	localparam logic [10:0] COB_SYNC = 11'h080;
	localparam logic [10:0] COB_TPDO = 11'h180;
	localparam logic [10:0] COB_SDO_TX = 11'h580;
	localparam logic [10:0] COB_SDO_RX = 11'h600;
	localparam logic [10:0] COB_HB = 11'h700;
	localparam logic [3:0] DLC_NMT = 4'h2;
	localparam logic [3:0] DLC_SDO = 4'h8;
	localparam logic [3:0] DLC_HB = 4'h1;
	localparam logic [3:0] DLC_PDO = 4'h4;
	// Network management commands and the heartbeat state bytes.
	localparam logic [7:0] NMT_START = 8'h01;
	localparam logic [7:0] NMT_STOP = 8'h02;
	localparam logic [7:0] NMT_PREOP = 8'h80;
	localparam logic [7:0] NMT_RST_NODE = 8'h81;
	localparam logic [7:0] NMT_RST_COMM = 8'h82;
	localparam logic [7:0] HB_BOOT = 8'h00;
	localparam logic [7:0] HB_STOP = 8'h04;
	localparam logic [7:0] HB_OPER = 8'h05;
	localparam logic [7:0] HB_PREOP = 8'h7F;
	typedef enum logic [3:0] {
		NS_INIT = 4'h1,
		NS_PREOP = 4'h2,
		NS_OPER = 4'h4,
		NS_STOP = 4'h8
	} cnod_nmt_e;
	// SDO command bytes and abort codes.
	localparam logic [7:0] SDO_RD_REQ = 8'h40;
	localparam logic [2:0] SDO_WR_CCS = 3'h1;
	localparam logic [7:0] SDO_RD_RSP = 8'h43;
	localparam logic [7:0] SDO_WR_RSP = 8'h60;
	localparam logic [7:0] SDO_ABORT = 8'h80;
	localparam logic [31:0] ABT_TIMEOUT = 32'h05040000;
	localparam logic [31:0] ABT_CMD = 32'h05040001;
	localparam logic [31:0] ABT_RO = 32'h06010002;
	localparam logic [31:0] ABT_NO_OBJ = 32'h06020000;
	localparam logic [31:0] ABT_RANGE = 32'h06090030;
	// Dictionary areas and objects.
	localparam logic [15:0] IDX_TYPE_LO = 16'h0001;
	localparam logic [15:0] IDX_STD_HI = 16'h001F;
	localparam logic [15:0] IDX_TYPE_HI = 16'h009F;
	localparam logic [15:0] IDX_COMM_LO = 16'h1000;
	localparam logic [15:0] IDX_COMM_HI = 16'h1FFF;
	localparam logic [15:0] IDX_MFR_LO = 16'h2000;
	localparam logic [15:0] IDX_MFR_HI = 16'h5FFF;
	localparam logic [15:0] IDX_PROF_LO = 16'h6000;
	localparam logic [15:0] IDX_PROF_HI = 16'h9FFF;
	localparam logic [15:0] OD_DEVTYPE = 16'h1000;
	localparam logic [15:0] OD_ERRREG = 16'h1001;
	localparam logic [15:0] OD_HBT = 16'h1017;
	localparam logic [15:0] OD_IDENT = 16'h1018;
	localparam logic [15:0] OD_RATE = 16'h2000;
	localparam logic [15:0] OD_VALUE = 16'h6000;
	localparam logic [7:0] IDENT_SUBS = 8'h04;
endpackage

//--- logic/cnod_if.sv
// Frame-level link between the CANopen master end and the node end.
`timescale 1ns/1ps
interface cnod_if;
	logic h2d_valid;
	logic h2d_ready;
	cnod_pkg::cnod_frame_s h2d_frame;
	logic d2h_valid;
	logic d2h_ready;
	cnod_pkg::cnod_frame_s d2h_frame;
	modport dev (
		input h2d_valid,
		input h2d_frame,
		input d2h_ready,
		output h2d_ready,
		output d2h_valid,
		output d2h_frame
	);
	modport host (
		output h2d_valid,
		output h2d_frame,
		output d2h_ready,
		input h2d_ready,
		input d2h_valid,
		input d2h_frame
	);
endinterface

//--- logic/cnod_bit_timer.sv
// Bit timer: prescaler to time quanta and a sample-point tick per bit.
`timescale 1ns/1ps
module cnod_bit_timer (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic [2:0] rate,
	output logic sample_tick
);
	import cnod_pkg::*;
	logic [11:0] pre_q;
	logic [3:0] tq_q;
	logic [11:0] presc;
	logic rate_ok;
	logic tq_end;

	// Prescale per rate; unsupported codes stop the timer.
	assign presc = (rate == RATE_500K) ? PRE_500K :
		(rate == RATE_250K) ? PRE_250K :
		(rate == RATE_125K) ? PRE_125K :
		(rate == RATE_100K) ? PRE_100K :
		(rate == RATE_50K) ? PRE_50K :
		(rate == RATE_20K) ? PRE_20K : PRE_10K;
	assign rate_ok = (rate <= RATE_10K); // RQ3
	assign tq_end = rate_ok && (pre_q == presc - 12'h001); // RQ21

	// Count quanta within a bit and mark the sample point.
	always_ff @(posedge ref_clk) begin
		if (rst || !rate_ok) begin
			pre_q <= 12'h000;
			tq_q <= 4'h0;
			sample_tick <= 1'b0;
		end else begin
			pre_q <= tq_end ? 12'h000 : pre_q + 12'h001;
			tq_q <= tq_end ? ((tq_q == LAST_TQ) ? 4'h0 : tq_q + 4'h1) : tq_q;
			sample_tick <= tq_end && (tq_q == SAMPLE_TQ); // RQ21
		end
	end
endmodule

//--- logic/cnod_device.sv
// CANopen node end: NMT states, SDO server, sync PDO and heartbeat.
// Functional notes
// RQ1 - Frames follow CAN 2.0B, extended format carried.
// RQ2 - Rates 500 down to 10 kbit/s selectable.
// RQ3 - No 1 Mbit/s or 800 kbit/s rate.
// RQ4 - SDO answer within 150 ms.
// RQ5 - SDO answer typically under 10 ms.
// RQ6 - Objects selected by 16-bit index.
// RQ7 - Elements selected by 8-bit sub-index.
// RQ8 - Communication objects at 1000 to 1FFF.
// RQ9 - Maker objects at 2000 to 5FFF.
// RQ10 - Profile objects 6000 to 9FFF, rest reserved.
// RQ11 - Data type definitions at 0001 to 009F.
// RQ12 - Boot-up frame within 5 s of power.
// RQ13 - Pre-operational: only heartbeat sent spontaneously.
// RQ14 - Written communication parameters saved automatically.
// RQ15 - Start command honoured broadcast or addressed.
// RQ16 - Serve SDO reads and writes.
// RQ17 - Services gated by network state.
// RQ18 - SDO server only, never a client.
// RQ19 - SDO answers use 0x580 plus node.
// RQ20 - SDO requests arrive on 0x600 plus node.
// RQ21 - Prescaled bit timing, rate kept over reset.
// RQ22 - Init, boot-up, then command-driven states.
`timescale 1ns/1ps
module cnod_device #(
	parameter int BOOT_CYCLES = cnod_pkg::BOOT_CYC,
	parameter int MS_CYCLES = cnod_pkg::MS_CYC,
	// Bit times the bus stays busy after each frame.
	parameter logic [7:0] GAP_BITS = cnod_pkg::FRAME_BITS,
	parameter logic [31:0] DEV_TYPE = 32'h00000000,
	// Identity values below are arbitrary.
	parameter logic [31:0] VENDOR_ID = 32'h00000ABC,
	parameter logic [31:0] PRODUCT_ID = 32'h00000001,
	parameter logic [31:0] REVISION_ID = 32'h00000001,
	parameter logic [31:0] SERIAL_NO = 32'h00000001
) (
	input wire logic ref_clk,
	input wire logic rst,
	cnod_if.dev link,
	input wire logic [6:0] node_id,
	input wire logic [2:0] nv_rate_in,
	input wire logic [15:0] nv_hbt_in,
	input wire logic [31:0] sensor_val,
	output logic nv_save,
	output logic [2:0] nv_rate_out,
	output logic [15:0] nv_hbt_out,
	output cnod_pkg::cnod_nmt_e nmt_state,
	output logic sample_tick
);
	import cnod_pkg::*;
	cnod_nmt_e nmt_q;
	cnod_nmt_e nmt_d;
	cnod_frame_s rf;
	cnod_frame_s sdo_rsp_q;
	cnod_frame_s tx_q;
	logic tx_v_q;
	logic load_q;
	logic [2:0] rate_q;
	logic [15:0] hbt_q;
	logic [31:0] boot_cnt_q;
	logic [31:0] ms_cnt_q;
	logic [15:0] hb_cnt_q;
	logic [7:0] gap_q;
	logic boot_pend_q;
	logic sdo_pend_q;
	logic pdo_pend_q;
	logic hb_pend_q;
	logic [31:0] pdo_val_q;

	assign nmt_state = nmt_q;
	assign nv_rate_out = rate_q;
	assign nv_hbt_out = hbt_q;
	assign link.d2h_valid = tx_v_q;
	assign link.d2h_frame = tx_q;

	// Bit timing runs from the stored rate code.
	cnod_bit_timer u_timer (
		.ref_clk(ref_clk),
		.rst(rst),
		.rate(rate_q),
		.sample_tick(sample_tick)
	);

	// Receive decode; frames are taken only while no SDO answer or PDO waits.
	logic rx_take;
	logic [10:0] rid;
	logic st_init;
	logic st_preop;
	logic st_oper;
	logic sdo_ok;
	logic is_nmt;
	logic is_sync;
	logic is_sdo;
	logic nmt_me;
	assign rf = link.h2d_frame;
	assign link.h2d_ready = !sdo_pend_q && !pdo_pend_q;
	assign rx_take = link.h2d_valid && link.h2d_ready;
	assign rid = rf.id[10:0];
	assign st_init = (nmt_q == NS_INIT);
	assign st_preop = (nmt_q == NS_PREOP);
	assign st_oper = (nmt_q == NS_OPER);
	assign sdo_ok = st_preop || st_oper; // RQ17
	assign is_nmt = rx_take && !rf.ide && (rid == COB_NMT) && !st_init; // RQ17
	assign is_sync = rx_take && !rf.ide && (rid == COB_SYNC) && sdo_ok; // RQ17
	assign is_sdo = rx_take && !rf.ide && sdo_ok && (rf.dlc == DLC_SDO)
		&& (rid == COB_SDO_RX + {4'h0, node_id}); // RQ20
	assign nmt_me = (rf.data[15:8] == 8'h00) ||
		(rf.data[15:8] == {1'b0, node_id}); // RQ15

	// SDO request fields and dictionary area decode.
	logic [7:0] cmd;
	logic [15:0] idx;
	logic [7:0] sub;
	logic [31:0] wdat;
	logic is_rd;
	logic is_wr;
	logic in_type;
	logic in_comm;
	logic in_mfr;
	logic in_prof;
	assign cmd = rf.data[7:0];
	assign idx = rf.data[23:8]; // RQ6
	assign sub = rf.data[31:24]; // RQ7
	assign wdat = rf.data[63:32];
	assign is_rd = (cmd == SDO_RD_REQ); // RQ16
	assign is_wr = (cmd[7:5] == SDO_WR_CCS); // RQ16
	assign in_type = (idx >= IDX_TYPE_LO) && (idx <= IDX_TYPE_HI); // RQ11
	assign in_comm = (idx >= IDX_COMM_LO) && (idx <= IDX_COMM_HI); // RQ8
	assign in_mfr = (idx >= IDX_MFR_LO) && (idx <= IDX_MFR_HI); // RQ9
	assign in_prof = (idx >= IDX_PROF_LO) && (idx <= IDX_PROF_HI); // RQ10

	// Object hits; anything outside the areas is reserved and absent.
	logic hit_dev;
	logic hit_err;
	logic hit_hbt;
	logic hit_id;
	logic hit_rate;
	logic hit_val;
	logic hit_any;
	logic hit_rw;
	logic bad_rate;
	assign hit_dev = in_comm && (idx == OD_DEVTYPE) && (sub == 8'h00); // RQ8
	assign hit_err = in_comm && (idx == OD_ERRREG) && (sub == 8'h00); // RQ8
	assign hit_hbt = in_comm && (idx == OD_HBT) && (sub == 8'h00); // RQ8
	assign hit_id = in_comm && (idx == OD_IDENT) && (sub <= IDENT_SUBS);
	assign hit_rate = in_mfr && (idx == OD_RATE) && (sub == 8'h00); // RQ9
	assign hit_val = in_prof && (idx == OD_VALUE) && (sub == 8'h00); // RQ10
	assign hit_any = hit_dev || hit_err || hit_hbt || hit_id || hit_rate
		|| hit_val || in_type; // RQ10
	assign hit_rw = hit_hbt || hit_rate;
	assign bad_rate = hit_rate && (wdat[31:3] != 29'h0 || wdat[2:0] > RATE_10K);

	// Read value and abort code selection.
	logic [31:0] id_val;
	logic [31:0] rd_val;
	logic [31:0] abt;
	logic do_abt;
	logic do_wr;
	assign id_val = (sub == 8'h00) ? {24'h0, IDENT_SUBS} :
		(sub == 8'h01) ? VENDOR_ID : (sub == 8'h02) ? PRODUCT_ID :
		(sub == 8'h03) ? REVISION_ID : SERIAL_NO;
	assign rd_val = hit_dev ? DEV_TYPE : hit_hbt ? {16'h0, hbt_q} :
		hit_id ? id_val : hit_rate ? {29'h0, rate_q} :
		hit_val ? sensor_val : 32'h0; // RQ16
	assign abt = (!is_rd && !is_wr) ? ABT_CMD : !hit_any ? ABT_NO_OBJ :
		(is_wr && !hit_rw) ? ABT_RO : ABT_RANGE;
	assign do_abt = !(is_rd || is_wr) || !hit_any ||
		(is_wr && (!hit_rw || bad_rate));
	assign do_wr = is_sdo && is_wr && !do_abt;

	// The answer is built in the cycle the request is taken; it goes out once
	// any frame in flight and the GAP_BITS gap after it are done, inside the worst bound.
	always_ff @(posedge ref_clk) begin
		if (is_sdo) begin // RQ4 RQ5
			sdo_rsp_q.id <= {18'h0, COB_SDO_TX + {4'h0, node_id}}; // RQ19
			sdo_rsp_q.ide <= 1'b0;
			sdo_rsp_q.dlc <= DLC_SDO;
			sdo_rsp_q.data <= do_abt ? {abt, sub, idx, SDO_ABORT} :
				is_rd ? {rd_val, sub, idx, SDO_RD_RSP} :
				{32'h0, sub, idx, SDO_WR_RSP};
		end
	end

	// Stored parameters: defaults at reset, then restored from storage
	// one cycle after release; every accepted write is saved at once.
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			load_q <= 1'b1;
			rate_q <= RATE_DEF;
			hbt_q <= 16'h0000;
			nv_save <= 1'b0;
		end else begin
			load_q <= 1'b0;
			nv_save <= do_wr; // RQ14
			if (load_q) begin
				rate_q <= (nv_rate_in <= RATE_10K) ? nv_rate_in : RATE_DEF; // RQ21
				hbt_q <= nv_hbt_in;
			end else if (do_wr && hit_rate) begin
				rate_q <= wdat[2:0]; // RQ2
			end else if (do_wr && hit_hbt) begin
				hbt_q <= wdat[15:0];
			end
		end
	end

	// Network state: commands act only after initialization.
	always_comb begin
		nmt_d = nmt_q;
		if (st_init && boot_pend_q && !tx_v_q && gap_q == 8'h00) begin
			nmt_d = NS_PREOP; // RQ22
		end else if (is_nmt && nmt_me) begin
			case (rf.data[7:0])
				NMT_START: nmt_d = NS_OPER; // RQ15
				NMT_STOP: nmt_d = NS_STOP;
				NMT_PREOP: nmt_d = NS_PREOP;
				NMT_RST_NODE: nmt_d = NS_INIT;
				NMT_RST_COMM: nmt_d = NS_INIT;
				default: nmt_d = nmt_q;
			endcase
		end
	end

	// Transmit load, by priority: SDO answer, PDO, boot-up, heartbeat.
	logic tx_free;
	logic ld_sdo;
	logic ld_pdo;
	logic ld_hb;
	logic ld_boot;
	logic hb_fire;
	logic boot_fire;
	logic [7:0] hb_byte;
	assign tx_free = !tx_v_q && (gap_q == 8'h00);
	assign ld_sdo = tx_free && sdo_pend_q;
	assign ld_pdo = tx_free && !sdo_pend_q && pdo_pend_q && st_oper; // RQ17
	assign ld_hb = tx_free && !sdo_pend_q && !pdo_pend_q && hb_pend_q;
	assign ld_boot = tx_free && st_init && boot_pend_q; // RQ17
	assign hb_fire = !st_init && (hbt_q != 16'h0000) && (hb_cnt_q >= hbt_q)
		&& (ms_cnt_q == 32'(MS_CYCLES - 1)); // RQ13
	assign boot_fire = st_init && (boot_cnt_q == 32'(BOOT_CYCLES - 1));
	assign hb_byte = st_oper ? HB_OPER : st_preop ? HB_PREOP : HB_STOP;

	// Pending flags: a new event wins over the clear in the same cycle.
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			nmt_q <= NS_INIT;
			boot_pend_q <= 1'b0;
			sdo_pend_q <= 1'b0;
			pdo_pend_q <= 1'b0;
			hb_pend_q <= 1'b0;
			pdo_val_q <= 32'h0;
		end else begin
			nmt_q <= nmt_d;
			boot_pend_q <= boot_fire || (boot_pend_q && st_init && !ld_boot);
			sdo_pend_q <= is_sdo || (sdo_pend_q && !ld_sdo); // RQ18
			pdo_pend_q <= (is_sync && st_oper) ||
				(pdo_pend_q && st_oper && !ld_pdo); // RQ17
			hb_pend_q <= hb_fire || (hb_pend_q && !ld_hb && !st_init); // RQ13
			if (is_sync && st_oper) begin
				pdo_val_q <= sensor_val;
			end
		end
	end

	// Boot delay, millisecond base and heartbeat interval counters.
	always_ff @(posedge ref_clk) begin
		if (rst || !st_init) begin
			boot_cnt_q <= 32'h0;
		end else if (!boot_pend_q && !boot_fire) begin
			boot_cnt_q <= boot_cnt_q + 32'h1; // RQ12
		end
	end
	always_ff @(posedge ref_clk) begin
		if (rst || st_init) begin
			ms_cnt_q <= 32'h0;
			hb_cnt_q <= 16'h0001;
		end else if (ms_cnt_q == 32'(MS_CYCLES - 1)) begin
			ms_cnt_q <= 32'h0;
			hb_cnt_q <= hb_fire ? 16'h0001 : hb_cnt_q + 16'h0001;
		end else begin
			ms_cnt_q <= ms_cnt_q + 32'h1;
		end
	end

	// Output frame register; after each frame the bus is held busy for
	// GAP_BITS bit times at the selected rate (a frame's worth by default).
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			tx_v_q <= 1'b0;
			tx_q <= '0;
			gap_q <= 8'h00;
		end else if (tx_v_q) begin
			if (link.d2h_ready) begin
				tx_v_q <= 1'b0;
				gap_q <= GAP_BITS; // RQ21
			end
		end else if (gap_q != 8'h00) begin
			gap_q <= sample_tick ? gap_q - 8'h01 : gap_q;
		end else if (ld_sdo || ld_pdo || ld_hb || ld_boot) begin
			tx_v_q <= 1'b1;
			tx_q.ide <= 1'b0; // RQ1
			if (ld_sdo) begin
				tx_q <= sdo_rsp_q;
			end else if (ld_pdo) begin
				tx_q.id <= {18'h0, COB_TPDO + {4'h0, node_id}};
				tx_q.dlc <= DLC_PDO;
				tx_q.data <= {32'h0, pdo_val_q};
			end else begin
				tx_q.id <= {18'h0, COB_HB + {4'h0, node_id}}; // RQ12
				tx_q.dlc <= DLC_HB;
				tx_q.data <= {56'h0, ld_boot ? HB_BOOT : hb_byte};
			end
		end
	end
endmodule

//--- logic/cnod_host.sv
// CANopen master end: sends NMT, sync and SDO client frames.
`timescale 1ns/1ps
module cnod_host #(
	parameter int SDO_TO_CYCLES = cnod_pkg::SDO_MAX_CYC
) (
	input wire logic ref_clk,
	input wire logic rst,
	cnod_if.host link,
	input wire logic nmt_go,
	input wire logic [7:0] nmt_cmd,
	input wire logic [6:0] nmt_node,
	input wire logic sync_go,
	input wire logic sdo_go,
	input wire logic sdo_wr,
	input wire logic [6:0] sdo_node,
	input wire logic [15:0] sdo_idx,
	input wire logic [7:0] sdo_sub,
	input wire logic [31:0] sdo_wdata,
	output logic req_ready,
	output logic sdo_done,
	output logic sdo_err,
	output logic [31:0] sdo_rdata,
	output logic ev_valid,
	output cnod_pkg::cnod_frame_s ev_frame
);
	import cnod_pkg::*;
	cnod_frame_s tx_q;
	cnod_frame_s rf;
	logic tx_v_q;
	logic wait_q;
	logic [6:0] wnode_q;
	logic [31:0] to_q;
	logic rx_take;
	logic is_rsp;
	logic to_hit;

	// Requests are taken only while idle; NMT wins over SDO over sync.
	assign req_ready = !tx_v_q && !wait_q;
	assign link.h2d_valid = tx_v_q;
	assign link.h2d_frame = tx_q;
	assign link.d2h_ready = 1'b1;
	assign rf = link.d2h_frame;
	assign rx_take = link.d2h_valid;
	assign is_rsp = rx_take && wait_q && !rf.ide &&
		(rf.id[10:0] == COB_SDO_TX + {4'h0, wnode_q});
	assign to_hit = wait_q && (to_q == 32'(SDO_TO_CYCLES - 1));

	// Outgoing frame and outstanding-SDO tracking.
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			tx_v_q <= 1'b0;
			tx_q <= '0;
			wait_q <= 1'b0;
			wnode_q <= 7'h00;
		end else begin
			if (tx_v_q && link.h2d_ready) begin
				tx_v_q <= 1'b0;
			end
			if (is_rsp || to_hit) begin
				wait_q <= 1'b0;
			end
			if (req_ready && (nmt_go || sdo_go || sync_go)) begin
				tx_v_q <= 1'b1;
				tx_q.ide <= 1'b0;
				if (nmt_go) begin
					tx_q.id <= {18'h0, COB_NMT};
					tx_q.dlc <= DLC_NMT;
					tx_q.data <= {48'h0, 1'b0, nmt_node, nmt_cmd};
				end else if (sdo_go) begin // RQ20
					wait_q <= 1'b1;
					wnode_q <= sdo_node;
					tx_q.id <= {18'h0, COB_SDO_RX + {4'h0, sdo_node}};
					tx_q.dlc <= DLC_SDO;
					tx_q.data <= sdo_wr ?
						{sdo_wdata, sdo_sub, sdo_idx, {SDO_WR_CCS, 5'h03}} :
						{32'h0, sdo_sub, sdo_idx, SDO_RD_REQ};
				end else begin
					tx_q.id <= {18'h0, COB_SYNC};
					tx_q.dlc <= 4'h0;
					tx_q.data <= 64'h0;
				end
			end
		end
	end

	// Answer, timeout and event reporting toward the user side.
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			to_q <= 32'h0;
			sdo_done <= 1'b0;
			sdo_err <= 1'b0;
			sdo_rdata <= 32'h0;
			ev_valid <= 1'b0;
			ev_frame <= '0;
		end else begin
			to_q <= (wait_q && !is_rsp) ? to_q + 32'h1 : 32'h0;
			sdo_done <= is_rsp || to_hit;
			if (is_rsp) begin
				sdo_err <= (rf.data[7:0] == SDO_ABORT);
				sdo_rdata <= rf.data[63:32];
			end else if (to_hit) begin
				sdo_err <= 1'b1;
				sdo_rdata <= ABT_TIMEOUT;
			end
			ev_valid <= rx_take && !is_rsp;
			if (rx_take && !is_rsp) begin
				ev_frame <= rf;
			end
		end
	end
endmodule

//--- test/cnod_chk.sv
// Checker for the frame link between the master end and the node end.
`timescale 1ns/1ps
module cnod_chk #(
	parameter logic [6:0] NODE = 7'h01,
	parameter int SDO_LIM = 150000
) (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic h2d_valid,
	input wire logic h2d_ready,
	input wire cnod_pkg::cnod_frame_s h2d_frame,
	input wire logic d2h_valid,
	input wire logic d2h_ready,
	input wire cnod_pkg::cnod_frame_s d2h_frame
);
	import cnod_pkg::*;
	cnod_nmt_e st_q, st_d;
	logic pend_q, pend_d;
	int wait_q, wait_d;
	// Decoding of taken requests and sent frames, tracking the node state.
	wire [10:0] hid = h2d_frame.id[10:0];
	wire [10:0] cid = d2h_frame.id[10:0];
	wire [10:0] nid = {4'h0, NODE};
	wire [7:0] cmd = h2d_frame.data[7:0];
	wire [7:0] dst = h2d_frame.data[15:8];
	wire tk = h2d_valid && h2d_ready && !h2d_frame.ide;
	wire nmt = tk && hid == COB_NMT && st_q != NS_INIT
		&& (dst == 8'h00 || dst == {1'b0, NODE});
	wire sdo = tk && hid == COB_SDO_RX + nid && h2d_frame.dlc == DLC_SDO
		&& (st_q == NS_PREOP || st_q == NS_OPER);
	wire ans = d2h_valid && cid == COB_SDO_TX + nid;
	wire hb = d2h_valid && cid == COB_HB + nid;
	wire rstc = cmd == NMT_RST_NODE || cmd == NMT_RST_COMM;
	wire [7:0] b0 = d2h_frame.data[7:0];
	assign st_d = (hb && st_q == NS_INIT) ? NS_PREOP : !nmt ? st_q
		: cmd == NMT_START ? NS_OPER : cmd == NMT_STOP ? NS_STOP
		: cmd == NMT_PREOP ? NS_PREOP : rstc ? NS_INIT : st_q;
	assign pend_d = sdo || (pend_q && !ans);
	assign wait_d = pend_q ? wait_q + 1 : 0;
	// State copy and the wait counter of an outstanding request.
	always_ff @(posedge ref_clk) begin
		st_q <= rst ? NS_INIT : st_d;
		pend_q <= !rst && pend_d;
		wait_q <= rst ? 0 : wait_d;
	end
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (rst);
	property p_std; d2h_valid |-> !d2h_frame.ide; endproperty
	a_std: assert property (p_std)
		else $error("node sent an extended frame");
	property p_boot;
		d2h_valid && st_q == NS_INIT |->
			hb && d2h_frame.dlc == DLC_HB && b0 == HB_BOOT;
	endproperty
	a_boot: assert property (p_boot)
		else $error("first frame is not the boot-up frame");
	property p_quiet;
		st_q == NS_PREOP && d2h_valid |-> ans || (hb && b0 == HB_PREOP);
	endproperty
	a_quiet: assert property (p_quiet)
		else $error("spontaneous frame in pre-operational");
	property p_stop;
		st_q == NS_STOP |-> !d2h_valid || (hb && b0 == HB_STOP);
	endproperty
	a_stop: assert property (p_stop)
		else $error("frame other than heartbeat while stopped");
	property p_pdo; d2h_valid && cid[10:7] == 4'h3 |-> st_q == NS_OPER;
	endproperty
	a_pdo: assert property (p_pdo)
		else $error("process data outside operational");
	property p_sdo_id;
		d2h_valid && cid[10:7] == 4'hB |-> ans && d2h_frame.dlc == DLC_SDO;
	endproperty
	a_sdo_id: assert property (p_sdo_id)
		else $error("answer on wrong identifier or length");
	property p_server; d2h_valid |-> cid[10:7] != 4'hC; endproperty
	a_server: assert property (p_server)
		else $error("node sent a client request");
	property p_busy; sdo |=> !h2d_ready; endproperty
	a_busy: assert property (p_busy)
		else $error("request taken while an answer is pending");
	property p_time; pend_q |-> wait_q < SDO_LIM; endproperty
	a_time: assert property (p_time)
		else $error("answer later than the limit");
endmodule

//--- test/canopen_node_comm_logic_tb.sv
// Testbench joining the master end and the node end over the frame link.
`timescale 1ns/1ps
module canopen_node_comm_logic_tb;
	import cnod_pkg::*;
	localparam logic [6:0] NID = 7'h2A;
	localparam int TO_CYC = 2000;
	// Device type and serial number values are arbitrary.
	localparam logic [31:0] DEVT = 32'h00010191;
	localparam logic [31:0] SER = 32'h00005A5A;
	logic ref_clk = 0;
	logic rst = 1;
	logic [2:0] nv_rate_in = 3'h0;
	logic [31:0] sensor_val = 32'h0;
	logic nmt_go = 0, sync_go = 0, sdo_go = 0, sdo_wr = 0;
	logic [7:0] nmt_cmd = 8'h0, sdo_sub = 8'h0;
	logic [6:0] nmt_node = 7'h0;
	logic [15:0] sdo_idx = 16'h0;
	logic [31:0] sdo_wdata = 32'h0;
	logic nv_save, req_ready, sdo_done, sdo_err, ev_valid, sample_tick;
	logic [2:0] nv_rate_out;
	logic [15:0] nv_hbt_out;
	logic [31:0] sdo_rdata;
	cnod_nmt_e nmt_state;
	cnod_frame_s ev_frame;
	logic [43:0] exp_q[$];
	logic [43:0] mon_e, mon_s;
	int miscompares = 0, compares = 0, saves = 0, cyc = 0;
	int seed = 32'h8570;
	cnod_if link();
	cnod_device #(.BOOT_CYCLES(20), .MS_CYCLES(50), .GAP_BITS(8'h02),
		.DEV_TYPE(DEVT), .SERIAL_NO(SER)) u_cnod_device (.ref_clk(ref_clk),
		.rst(rst),
		.link(link), .node_id(NID), .nv_rate_in(nv_rate_in),
		.nv_hbt_in(16'h0000), .sensor_val(sensor_val), .nv_save(nv_save),
		.nv_rate_out(nv_rate_out), .nv_hbt_out(nv_hbt_out),
		.nmt_state(nmt_state), .sample_tick(sample_tick));
	cnod_host #(.SDO_TO_CYCLES(TO_CYC)) u_cnod_host (.ref_clk(ref_clk),
		.rst(rst), .link(link), .nmt_go(nmt_go), .nmt_cmd(nmt_cmd),
		.nmt_node(nmt_node), .sync_go(sync_go), .sdo_go(sdo_go),
		.sdo_wr(sdo_wr), .sdo_node(NID), .sdo_idx(sdo_idx),
		.sdo_sub(sdo_sub), .sdo_wdata(sdo_wdata), .req_ready(req_ready),
		.sdo_done(sdo_done), .sdo_err(sdo_err), .sdo_rdata(sdo_rdata),
		.ev_valid(ev_valid), .ev_frame(ev_frame));
	cnod_chk #(.NODE(NID), .SDO_LIM(TO_CYC)) u_cnod_chk (.ref_clk(ref_clk),
		.rst(rst), .h2d_valid(link.h2d_valid), .h2d_ready(link.h2d_ready),
		.h2d_frame(link.h2d_frame), .d2h_valid(link.d2h_valid),
		.d2h_ready(link.d2h_ready), .d2h_frame(link.d2h_frame));
	always #2.5 ref_clk = ~ref_clk;
	// Counts cycles and accepted saves to the non-volatile store.
	always @(posedge ref_clk) begin
		cyc <= cyc + 1;
		if (nv_save === 1'b1) saves <= saves + 1;
	end
	task chk(input string nm, input logic [43:0] e, input logic [43:0] s);
		compares++;
		if (s !== e) begin
			miscompares++;
			$display("wrong value %s expected %h seen %h", nm, e, s);
		end
	endtask
	// Each answer or received frame is matched with the oldest note.
	always @(posedge ref_clk) begin
		if (sdo_done === 1'b1 || ev_valid === 1'b1) begin
			mon_e = exp_q.size() ? exp_q.pop_front() : 44'hX;
			mon_s = (sdo_done === 1'b1) ? {11'h0, sdo_err, sdo_rdata}
				: {ev_frame.id[10:0], 1'b0, ev_frame.data[31:0]};
			chk("result", mon_e, mon_s);
		end
	end
	// Holds the request until the master end takes it, then drops it.
	task req(input logic [2:0] g);
		{nmt_go, sync_go, sdo_go} = g;
		@(posedge ref_clk);
		while (req_ready !== 1'b1) @(posedge ref_clk);
		@(negedge ref_clk);
		{nmt_go, sync_go, sdo_go} = 3'h0;
	endtask
	task sdo(input logic w, input logic [15:0] i, input logic [7:0] s,
		input logic [31:0] d, input logic [32:0] e);
		exp_q.push_back({11'h0, e});
		@(negedge ref_clk);
		sdo_wr = w;
		sdo_idx = i;
		sdo_sub = s;
		sdo_wdata = d;
		req(3'h1);
	endtask
	task nmt(input logic [7:0] c, input logic [6:0] n);
		@(negedge ref_clk);
		nmt_cmd = c;
		nmt_node = n;
		req(3'h4);
		repeat (4) @(negedge ref_clk);
	endtask
	task drain;
		while (exp_q.size() != 0) @(posedge ref_clk);
		@(negedge ref_clk);
	endtask
	task wrap_up;
		if (miscompares == 0 && compares > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask
	// Watchdog: a clean run ends inside 100,000 cycles.
	initial begin
		#500000;
		miscompares++;
		wrap_up;
	end
	initial begin
		static int rt[8] = '{500, 250, 125, 100, 50, 20, 10, 125};
		int t0;
		sensor_val = $random(seed);
		// Every rate code, the invalid one first, 500k at the end.
		for (int k = 7; k >= 0; k--) begin
			nv_rate_in = 3'(k);
			exp_q.push_back({COB_HB + 11'(NID), 33'h0});
			@(negedge ref_clk);
			rst = 1;
			repeat (k == 7 ? 10 : 2) @(negedge ref_clk);
			rst = 0;
			@(posedge ref_clk iff sample_tick === 1'b1);
			t0 = cyc;
			@(posedge ref_clk iff sample_tick === 1'b1);
			chk("bit", 44'(CLK_HZ / (rt[k] * 1000)), 44'(cyc - t0));
			chk("rate", 44'(k == 7 ? 2 : k), 44'(nv_rate_out));
			drain;
		end
		chk("state", 44'(NS_PREOP), 44'(nmt_state));
		@(negedge ref_clk);
		req(3'h2);
		sdo(1'b0, OD_DEVTYPE, 8'h00, 32'h0, {1'b0, DEVT});
		sdo(1'b0, OD_IDENT, 8'h04, 32'h0, {1'b0, SER});
		sdo(1'b0, OD_VALUE, 8'h00, 32'h0, {1'b0, sensor_val});
		sdo(1'b0, 16'h0005, 8'h03, 32'h0, 33'h0);
		sdo(1'b1, 16'h0010, 8'h00, 32'h0, {1'b1, ABT_RO});
		sdo(1'b0, 16'hA000, 8'h00, 32'h0, {1'b1, ABT_NO_OBJ});
		sdo(1'b1, OD_RATE, 8'h00, 32'h7, {1'b1, ABT_RANGE});
		drain;
		nmt(NMT_START, 7'h00);
		chk("state", 44'(NS_OPER), 44'(nmt_state));
		exp_q.push_back({COB_TPDO + 11'(NID), 1'b0, sensor_val});
		req(3'h2);
		drain;
		nmt(NMT_STOP, NID);
		chk("state", 44'(NS_STOP), 44'(nmt_state));
		sdo(1'b0, OD_ERRREG, 8'h00, 32'h0, {1'b1, ABT_TIMEOUT});
		drain;
		nmt(NMT_PREOP, NID);
		sdo(1'b1, OD_HBT, 8'h00, 32'h1, 33'h0);
		exp_q.push_back({COB_HB + 11'(NID), 25'h0, HB_PREOP});
		drain;
		chk("heartbeat", 44'h1, 44'(nv_hbt_out));
		chk("saves", 44'h1, 44'(saves));
		sdo(1'b1, OD_RATE, 8'h00, 32'h0, 33'h0);
		exp_q.push_back({COB_HB + 11'(NID), 33'h0});
		nmt(NMT_RST_COMM, 7'h00);
		drain;
		chk("state", 44'(NS_PREOP), 44'(nmt_state));
		chk("saves", 44'h2, 44'(saves));
		wrap_up;
	end
endmodule
